// >>> pkg/idt_pkg.sv
// Shared constants and types for the instruction decode and timing block
package idt_pkg;

    // ==========================================================
    // Register map (byte addresses on APB)
    localparam logic [7:0] ADDR_CTRL  = 8'h00; // Run enable
    localparam logic [7:0] ADDR_COND  = 8'h04; // Skip and pointer conditions
    localparam logic [7:0] ADDR_INSTR = 8'h08; // Instruction word to issue
    localparam logic [7:0] ADDR_DEC   = 8'h0C; // Latched decode result
    localparam logic [7:0] ADDR_STAT  = 8'h10; // Sequencer state

    // ==========================================================
    // Field positions
    localparam int COND_SKIP   = 0;  // Conditional skip test true
    localparam int COND_MSB0   = 1;  // Pointer 0 top bit
    localparam int COND_MSB1   = 2;  // Pointer 1 top bit
    localparam int DEC_CLS     = 0;  // Class, 2 bits
    localparam int DEC_CYC     = 2;  // Cycle count, 2 bits
    localparam int DEC_DEST    = 4;  // Result to file register
    localparam int DEC_FOP     = 5;  // Names a file register
    localparam int DEC_BIT     = 6;  // Bit index, 3 bits
    localparam int DEC_PSEL    = 9;  // Pointer select
    localparam int DEC_PMODE   = 10; // Pointer mode, 2 bits
    localparam int DEC_FADDR   = 12; // File address, 7 bits
    localparam int DEC_LIT     = 19; // Literal, 11 bits
    localparam int STAT_PEND   = 0;  // Word waiting to issue
    localparam int STAT_BUSY   = 1;  // Instruction executing
    localparam int STAT_CIDX   = 2;  // Cycle index, 2 bits
    localparam int STAT_Q      = 4;  // Oscillator phase, 2 bits

    // ==========================================================
    // Widths, reset values, timing
    localparam int          WORD_W       = 14;        // Instruction width
    localparam int          OSC_PER_ICYC = 4;         // Oscillator cycles per cycle
    localparam logic [1:0]  Q_LAST       = 2'(OSC_PER_ICYC - 1);
    localparam logic [1:0]  Q_READ       = 2'h1;      // Phase of file read
    localparam logic [13:0] INSTR_RST    = 14'h0000;  // Reset word
    localparam logic [2:0]  COND_RST     = 3'h0;

    // ==========================================================
    // Opcode constants
    localparam logic [6:0]  FADDR_PC     = 7'h02;   // Program counter low byte
    localparam logic [13:0] OP_RETURN    = 14'h0008;
    localparam logic [13:0] OP_RETINT    = 14'h0009;
    localparam logic [13:0] OP_CALL_VIA_WORKING_REG     = 14'h000A;
    localparam logic [13:0] OP_BRW       = 14'h000B;
    localparam logic [3:0]  OP_RETLIT    = 4'h4;    // Under top bits 2'h3
    localparam logic [2:0]  OP_RELBRA    = 3'h1;    // Under top bits 2'h3
    localparam logic [3:0]  OP_DECSKIP   = 4'hB;
    localparam logic [3:0]  OP_INCSKIP   = 4'hF;
    localparam logic [2:0]  OP_INDMOVE   = 3'h1;    // Bits 6:4 of control word
    localparam logic [4:0]  OP_INDOFS    = 5'h1E;   // Offset move, bits 11:7

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CLS_BYTE = 2'b00,
        CLS_BIT  = 2'b01,
        CLS_CTRL = 2'b10
    } idt_cls_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } idt_state_type;

endpackage

// >>> rtl/idt_classify.sv
// Combinational classifier and operand extractor for one instruction word
`timescale 1ns/10ps
module idt_classify (
    input  wire logic [13:0]        word,
    input  wire logic               skip_taken,
    input  wire logic               ptr0_msb,
    input  wire logic               ptr1_msb,
    output idt_pkg::idt_cls_type    cls,
    output logic      [1:0]         cycles,
    output logic                    dest_file,
    output logic                    file_op,
    output logic      [2:0]         bit_idx,
    output logic                    ptr_sel,
    output logic      [1:0]         ptr_mode,
    output logic      [6:0]         file_addr,
    output logic      [10:0]        literal
);

    logic [1:0] top;      // Two top opcode bits
    logic       ctl0;     // Control group under top bits 0
    logic       byte11;   // Byte ops under top bits 3
    logic       is_byte;
    logic       is_bit;
    logic       two;      // Needs a second cycle
    logic       indmove;  // Pointer move with mode
    logic       indofs;   // Pointer move with offset
    logic       ind_ref;  // References an indirect register
    logic       extra;    // Added cycle for program-memory pointer

    // ==========================================================
    // Classification
    always_comb begin
        top     = word[13:12];
        ctl0    = (top == 2'h0) && (word[11:7] == 5'h00);
        byte11  = (top == 2'h3) && (word[11:8] == 4'h7 || word[11:8] == 4'h5
                  || word[11:8] == 4'h6 || word[11:8] == 4'hD || word[11:8] == 4'hB);
        is_byte = ((top == 2'h0) && !ctl0) || byte11;
        is_bit  = (top == 2'h1);
        // Three classes, opcode only; don't-care bits never compared
        if (is_byte) begin
            cls = idt_pkg::CLS_BYTE;
        end else if (is_bit) begin
            cls = idt_pkg::CLS_BIT;
        end else begin
            cls = idt_pkg::CLS_CTRL;
        end
        // Whole operand set comes from the single word
        file_op   = is_byte || is_bit;
        file_addr = word[6:0];
        bit_idx   = word[9:7];
        literal   = word[10:0];
        // Result to W when d is 0, to the file when 1
        dest_file = is_byte ? word[7] : (is_bit && !word[11]);
        indmove   = ctl0 && (word[6:4] == idt_pkg::OP_INDMOVE);
        indofs    = (top == 2'h3) && (word[11:7] == idt_pkg::OP_INDOFS);
        ind_ref   = file_op && (word[6:1] == 6'h00);
        // Pointer number and mode
        if (indmove) begin
            ptr_sel  = word[2];
            ptr_mode = word[1:0];
        end else if (indofs) begin
            ptr_sel  = word[6];
            ptr_mode = 2'h0;
        end else begin
            ptr_sel  = word[0];
            ptr_mode = 2'h0;
        end
        // Calls, returns, branches, taken skips, writes to PC
        two = ((top == 2'h2) || word == idt_pkg::OP_CALL_VIA_WORKING_REG || word == idt_pkg::OP_RETURN
              || word == idt_pkg::OP_RETINT || word == idt_pkg::OP_BRW
              || ((top == 2'h3) && word[11:8] == idt_pkg::OP_RETLIT)
              || ((top == 2'h3) && word[11:9] == idt_pkg::OP_RELBRA)
              || (skip_taken && ((is_bit && word[11])
                  || ((top == 2'h0) && (word[11:8] == idt_pkg::OP_DECSKIP
                      || word[11:8] == idt_pkg::OP_INCSKIP))))
              || (is_byte && word[7] && word[6:0] == idt_pkg::FADDR_PC));
        // Pointer into program memory costs one more cycle
        extra  = (ind_ref || indmove || indofs) && (ptr_sel ? ptr1_msb : ptr0_msb);
        // One cycle unless an exception applies
        cycles = 2'h1 + {1'b0, two} + {1'b0, extra};
    end

endmodule

// >>> rtl/idt_core.sv
// Instruction decode and cycle timing core with APB register access
//
// Behaviour
// - One 14-bit word holds opcode and operands
// - Classify as byte, bit or literal/control
// - Default instruction takes one instruction cycle
// - Subroutine calls take two cycles
// - All three returns take two cycles
// - Jumps, branches and taken skips take two
// - Program-memory pointer reference adds one cycle
// - Instruction cycle is four oscillator cycles
// - File operands read, modify, then store
// - Read happens even for write-only instructions
// - File address spans 0x00 to 0x7F
// - Destination bit picks W or file
// - Bit index selects one of eight bits
// - Don't-care bits never change decode
// - Pointer select picks pointer 0 or 1
// - Two-bit mode picks pre/post inc/dec
// - PC change or true skip: second cycle idle
// - Pointer top bit set adds one cycle
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module idt_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             dec_valid,
    output logic      [1:0]  dec_class,
    output logic      [1:0]  dec_cycles,
    output logic             dec_dest_file,
    output logic      [6:0]  dec_file_addr,
    output logic      [2:0]  dec_bit_idx,
    output logic      [10:0] dec_literal,
    output logic             dec_ptr_sel,
    output logic      [1:0]  dec_ptr_mode,
    output logic             file_rd,
    output logic             file_wr,
    output logic             w_wr,
    output logic             nop_cycle,
    output logic             busy
);

    // ==========================================================
    // State record
    typedef struct packed {
        logic [1:0]             q;        // Oscillator phase within cycle
        logic                   run;      // Sequencer enable
        logic [2:0]             cond;     // Skip and pointer conditions
        logic [13:0]            instr;    // Last written word
        logic                   pend;     // Word waiting to issue
        idt_pkg::idt_state_type st;       // Sequencer state
        logic [1:0]             cidx;     // Instruction cycle index
        idt_pkg::idt_cls_type   cls;      // Latched decode
        logic [1:0]             cyc;
        logic                   dest;
        logic                   fop;
        logic [2:0]             bitx;
        logic                   psel;
        logic [1:0]             pmode;
        logic [6:0]             faddr;
        logic [10:0]            lit;
        logic                   dvalid;   // Issue pulse
        logic                   frd;      // File read strobe
        logic                   fwr;      // File write strobe
        logic                   wwr;      // W write strobe
        logic                   nop;      // Idle cycle marker
        logic                   rdy;      // APB ready
        logic                   err;      // APB error
        logic [31:0]            rdata;    // APB read data
    } idt_core_state_type;

    idt_core_state_type s_reg;   // Current state
    idt_core_state_type s_next;  // Next state

    // Classifier outputs
    idt_pkg::idt_cls_type c_cls;
    logic [1:0]           c_cyc;
    logic                 c_dest;
    logic                 c_fop;
    logic [2:0]           c_bit;
    logic                 c_psel;
    logic [1:0]           c_pmode;
    logic [6:0]           c_faddr;
    logic [10:0]          c_lit;

    // Helper terms
    logic tick;    // Last oscillator phase of a cycle
    logic done;    // Instruction ends at this tick
    logic start;   // Next word issues at this tick
    logic acc;     // APB access phase without answer yet
    logic fin;     // APB transfer completes here
    logic hit;     // Address is mapped

    // ==========================================================
    // Decoder for the pending word
    idt_classify u_cls (
        .word       (s_reg.instr),
        .skip_taken (s_reg.cond[idt_pkg::COND_SKIP]),
        .ptr0_msb   (s_reg.cond[idt_pkg::COND_MSB0]),
        .ptr1_msb   (s_reg.cond[idt_pkg::COND_MSB1]),
        .cls        (c_cls),
        .cycles     (c_cyc),
        .dest_file  (c_dest),
        .file_op    (c_fop),
        .bit_idx    (c_bit),
        .ptr_sel    (c_psel),
        .ptr_mode   (c_pmode),
        .file_addr  (c_faddr),
        .literal    (c_lit)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        s_next        = s_reg;
        s_next.dvalid = 1'b0;
        s_next.frd    = 1'b0;
        s_next.fwr    = 1'b0;
        s_next.wwr    = 1'b0;
        tick  = s_reg.run && (s_reg.q == idt_pkg::Q_LAST);
        done  = tick && (s_reg.st == idt_pkg::ST_EXEC) && (s_reg.cidx == s_reg.cyc - 2'h1);
        start = tick && s_reg.pend && ((s_reg.st == idt_pkg::ST_IDLE) || done);
        acc   = psel && penable && !s_reg.rdy;
        fin   = psel && penable && s_reg.rdy;
        hit   = (paddr == idt_pkg::ADDR_CTRL) || (paddr == idt_pkg::ADDR_COND)
                || (paddr == idt_pkg::ADDR_INSTR) || (paddr == idt_pkg::ADDR_DEC)
                || (paddr == idt_pkg::ADDR_STAT);
        // Four-phase divider
        if (s_reg.run) begin
            s_next.q = s_reg.q + 2'h1;
        end
        // Phase strobes in the first cycle only
        if (s_reg.run && s_reg.st == idt_pkg::ST_EXEC && s_reg.cidx == 2'h0) begin
            if (s_reg.q == idt_pkg::Q_READ && s_reg.fop) begin
                s_next.frd = 1'b1;
            end
            if (tick) begin
                s_next.fwr = s_reg.fop && s_reg.dest;
                s_next.wwr = (s_reg.cls == idt_pkg::CLS_BYTE) && !s_reg.dest;
            end
        end
        // Cycle sequencing
        if (start) begin
            // Issue: latch decode for the execution logic
            s_next.pend   = 1'b0;
            s_next.st     = idt_pkg::ST_EXEC;
            s_next.cidx   = 2'h0;
            s_next.cls    = c_cls;
            s_next.cyc    = c_cyc;
            s_next.dest   = c_dest;
            s_next.fop    = c_fop;
            s_next.bitx   = c_bit;
            s_next.psel   = c_psel;
            s_next.pmode  = c_pmode;
            s_next.faddr  = c_faddr;
            s_next.lit    = c_lit;
            s_next.dvalid = 1'b1;
            s_next.nop    = 1'b0;
        end else if (done) begin
            // Instruction ended, nothing waiting
            s_next.st  = idt_pkg::ST_IDLE;
            s_next.nop = 1'b0;
        end else if (tick && s_reg.st == idt_pkg::ST_EXEC) begin
            // Later cycles execute as no-operation
            s_next.cidx = s_reg.cidx + 2'h1;
            s_next.nop  = 1'b1;
        end
        // APB answer one cycle into the access phase
        s_next.rdy = acc;
        if (acc) begin
            s_next.err   = !hit;
            s_next.rdata = 32'h0000_0000;
            unique case (paddr)
                idt_pkg::ADDR_CTRL:  s_next.rdata[0] = s_reg.run;
                idt_pkg::ADDR_COND:  s_next.rdata[2:0] = s_reg.cond;
                idt_pkg::ADDR_INSTR: s_next.rdata[13:0] = s_reg.instr;
                idt_pkg::ADDR_DEC: begin
                    s_next.rdata[idt_pkg::DEC_CLS +: 2]   = s_reg.cls;
                    s_next.rdata[idt_pkg::DEC_CYC +: 2]   = s_reg.cyc;
                    s_next.rdata[idt_pkg::DEC_DEST]       = s_reg.dest;
                    s_next.rdata[idt_pkg::DEC_FOP]        = s_reg.fop;
                    s_next.rdata[idt_pkg::DEC_BIT +: 3]   = s_reg.bitx;
                    s_next.rdata[idt_pkg::DEC_PSEL]       = s_reg.psel;
                    s_next.rdata[idt_pkg::DEC_PMODE +: 2] = s_reg.pmode;
                    s_next.rdata[idt_pkg::DEC_FADDR +: 7] = s_reg.faddr;
                    s_next.rdata[idt_pkg::DEC_LIT +: 11]  = s_reg.lit;
                end
                idt_pkg::ADDR_STAT: begin
                    s_next.rdata[idt_pkg::STAT_PEND]      = s_reg.pend;
                    s_next.rdata[idt_pkg::STAT_BUSY]      = s_reg.st == idt_pkg::ST_EXEC;
                    s_next.rdata[idt_pkg::STAT_CIDX +: 2] = s_reg.cidx;
                    s_next.rdata[idt_pkg::STAT_Q +: 2]    = s_reg.q;
                end
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end else begin
            s_next.err = 1'b0;
        end
        // Writes take effect at the completing edge
        if (fin && pwrite) begin
            unique case (paddr)
                idt_pkg::ADDR_CTRL:  s_next.run = pwdata[0];
                idt_pkg::ADDR_COND:  s_next.cond = pwdata[2:0];
                idt_pkg::ADDR_INSTR: begin
                    // New word wins over a same-cycle issue
                    s_next.instr = pwdata[13:0];
                    s_next.pend  = 1'b1;
                end
                default: s_next.run = s_reg.run;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg       <= '0;
            s_reg.instr <= idt_pkg::INSTR_RST;
            s_reg.cond  <= idt_pkg::COND_RST;
            s_reg.st    <= idt_pkg::ST_IDLE;
            s_reg.cls   <= idt_pkg::CLS_BYTE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs, all from flops
    assign prdata        = s_reg.rdata;
    assign pready        = s_reg.rdy;
    assign pslverr       = s_reg.err;
    assign dec_valid     = s_reg.dvalid;
    assign dec_class     = s_reg.cls;
    assign dec_cycles    = s_reg.cyc;
    assign dec_dest_file = s_reg.dest;
    assign dec_file_addr = s_reg.faddr;
    assign dec_bit_idx   = s_reg.bitx;
    assign dec_literal   = s_reg.lit;
    assign dec_ptr_sel   = s_reg.psel;
    assign dec_ptr_mode  = s_reg.pmode;
    assign file_rd       = s_reg.frd;
    assign file_wr       = s_reg.fwr;
    assign w_wr          = s_reg.wwr;
    assign nop_cycle     = s_reg.nop;
    assign busy          = s_reg.st == idt_pkg::ST_EXEC;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !s_reg.run);

    // Busy spans of one and two instruction cycles, and the end check
    sequence one_cyc_s;
        busy [*4];
    endsequence
    sequence two_cyc_s;
        busy [*8];
    endsequence
    sequence ends_s;
        !busy || dec_valid;
    endsequence

    phase_period_a: assert property (tick |=> !tick [*3] ##1 tick)
        else $error("phase divider not four long");
    single_cycle_a: assert property (dec_valid && dec_cycles == 2'h1 |->
        one_cyc_s ##1 ends_s)
        else $error("one-cycle instruction wrong length");
    double_cycle_a: assert property (dec_valid && dec_cycles == 2'h2 |->
        two_cyc_s ##1 ends_s)
        else $error("two-cycle instruction wrong length");
    triple_cycle_a: assert property (dec_valid && dec_cycles == 2'h3 |->
        two_cyc_s ##1 one_cyc_s ##1 ends_s)
        else $error("three-cycle instruction wrong length");
    read_first_a: assert property (dec_valid && dec_dest_file |->
        ##2 file_rd ##2 file_wr)
        else $error("file write not preceded by read");
    // Every file operand is read in its first cycle, write-only ones too
    read_always_a: assert property (dec_valid && s_reg.fop |->
        ##2 file_rd)
        else $error("file operand not read");
    // Destination of the instruction that launched the strobe, not a newer issue
    dest_split_a: assert property (file_wr |-> $past(s_reg.dest) && !w_wr)
        else $error("destination select ignored");
    idle_cycle_a: assert property (nop_cycle |-> busy && !dec_valid && !file_rd)
        else $error("no-operation cycle misplaced");
    // Bus answers whether or not the sequencer runs
    apb_answer_a: assert property (disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");

endmodule

// >>> testbench/idt_prog_mem.sv
// Program memory model supplying the instruction words used by the bench
`timescale 1ns/10ps
module idt_prog_mem (
    input  wire logic [4:0]  addr,
    output logic      [13:0] word
);
    // ==========================================================
    // Instruction image: one whole 14-bit word per location
    localparam logic [13:0] IMAGE [32] = '{
        14'h07A5, 14'h077F, 14'h00B0, 14'h1290, 14'h1F85, 14'h1805, 14'h0BA0, 14'h0F20,
        14'h2123, 14'h000A, 14'h2FFF, 14'h0008, 14'h3455, 14'h0009, 14'h3200, 14'h000B,
        14'h3055, 14'h0780, 14'h0781, 14'h0B80, 14'h0082, 14'h0100, 14'h0103, 14'h0000,
        14'h0010, 14'h0011, 14'h0012, 14'h0013, 14'h0014, 14'h0015, 14'h0016, 14'h0017
    };
    // Combinational fetch, no extension words
    assign word = IMAGE[addr];
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the decode and timing core
`timescale 1ns/10ps
module tb_top;
    // ==========================================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        dec_valid, dec_dest_file, dec_ptr_sel, file_rd, file_wr, w_wr;
    logic        nop_cycle, busy;
    logic [1:0]  dec_class, dec_cycles, dec_ptr_mode;
    logic [6:0]  dec_file_addr;
    logic [2:0]  dec_bit_idx;
    logic [10:0] dec_literal;
    logic [4:0]  pm_addr;
    logic [13:0] pm_word;
    int          num_errors, cmp_count, idle;

    // Clock, 20 ns period
    always #10 pclk = ~pclk;

    idt_core dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dec_valid(dec_valid),
        .dec_class(dec_class), .dec_cycles(dec_cycles), .dec_dest_file(dec_dest_file),
        .dec_file_addr(dec_file_addr), .dec_bit_idx(dec_bit_idx),
        .dec_literal(dec_literal), .dec_ptr_sel(dec_ptr_sel),
        .dec_ptr_mode(dec_ptr_mode), .file_rd(file_rd), .file_wr(file_wr),
        .w_wr(w_wr), .nop_cycle(nop_cycle), .busy(busy)
    );
    idt_prog_mem mem_u (.addr(pm_addr), .word(pm_word));

    // ==========================================================
    // Verdict and comparison
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ==========================================================
    // APB transfer: setup, access held until pready sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            num_errors++;
            conclude();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Fetch a word from program memory and hand it over with its conditions
    task automatic stage(input logic [4:0] idx, input logic [2:0] cond);
        pm_addr = idx;
        #1;
        apb(1'h1, idt_pkg::ADDR_COND, {29'h0, cond});
        apb(1'h1, idt_pkg::ADDR_INSTR, {18'h0, pm_word});
    endtask

    // Wait for issue, then count activity over 16 clocks, past the longest instruction
    task automatic obs(input logic [1:0] cls, input logic [1:0] cyc, input logic [3:0] io);
        int n = 0, nb = 0, nn = 0, nr = 0, nw = 0, nq = 0, ra = 0, wa = 0;
        while (dec_valid !== 1'h1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (dec_valid !== 1'h1) begin
            num_errors++;
            conclude();
        end
        if (cls != 2'h3) check("class", dec_class, cls);
        check("cycles", dec_cycles, cyc);
        for (int k = 0; k < 16; k++) begin
            if (busy === 1'h1) nb++;
            if (nop_cycle === 1'h1) nn++;
            if (file_rd === 1'h1) nr++;
            if (file_rd === 1'h1) ra = k;
            if (file_wr === 1'h1) nw++;
            if (file_wr === 1'h1) wa = k;
            if (w_wr === 1'h1) nq++;
            @(posedge pclk);
            #1;
        end
        check("busy cycles", nb, 4 * cyc);
        check("idle cycles", nn, 4 * (cyc - 1));
        if (io[3] == 1'h0) begin
            check("file reads", nr, io[2]);
            check("file writes", nw, io[1]);
            check("w writes", nq, io[0]);
            if (nr > 0) check("read phase", ra, 2);
            if (nw > 0) check("store delay", wa, ra + 2);
        end
    endtask

    task automatic run(input logic [4:0] idx, input logic [2:0] cond, input logic [1:0] cls,
                       input logic [1:0] cyc, input logic [3:0] io);
        stage(idx, cond);
        obs(cls, cyc, io);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pm_addr = 5'h00;
        num_errors = 0;
        cmp_count = 0;
        idle = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        // Reset state, unmapped access refused
        apb(1'h0, idt_pkg::ADDR_STAT, 32'h0);
        check("status after reset", rd_data, 32'h0);
        apb(1'h0, 8'h14, 32'h0);
        check("unmapped read", rd_data, 32'h0);
        check("unmapped error", {31'h0, rd_err}, 32'h1);
        // Nothing issues while stopped, then byte op with d=1
        stage(5'h00, 3'h0);
        repeat (12) begin
            @(posedge pclk);
            #1;
            if (dec_valid === 1'h1) idle++;
        end
        check("issue while stopped", idle, 0);
        apb(1'h1, idt_pkg::ADDR_CTRL, 32'h1);
        obs(2'h0, 2'h1, 4'h6);
        check("file addr", dec_file_addr, 7'h25);
        check("dest", dec_dest_file, 1'h1);
        apb(1'h0, idt_pkg::ADDR_DEC, 32'h0);
        check("dec reg", {rd_data[18:12], rd_data[4], rd_data[3:0]}, {7'h25, 5'h14});
        run(5'h01, 3'h0, 2'h0, 2'h1, 4'h5);
        check("top file addr", dec_file_addr, 7'h7F);
        check("dest w", dec_dest_file, 1'h0);
        run(5'h02, 3'h0, 2'h0, 2'h1, 4'h6);
        run(5'h03, 3'h0, 2'h1, 2'h1, 4'h8);
        check("bit idx", dec_bit_idx, 3'h5);
        run(5'h04, 3'h1, 2'h1, 2'h2, 4'h8);
        check("bit idx top", dec_bit_idx, 3'h7);
        run(5'h05, 3'h0, 2'h1, 2'h1, 4'h8);
        run(5'h06, 3'h1, 2'h0, 2'h2, 4'h6);
        run(5'h07, 3'h0, 2'h0, 2'h1, 4'h5);
        run(5'h08, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h09, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h0A, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h0B, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h0C, 3'h0, 2'h2, 2'h2, 4'h0);
        check("literal", dec_literal, 11'h455);
        run(5'h0D, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h0E, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h0F, 3'h0, 2'h2, 2'h2, 4'h0);
        run(5'h10, 3'h0, 2'h2, 2'h1, 4'h0);
        run(5'h11, 3'h2, 2'h0, 2'h2, 4'h6);
        run(5'h12, 3'h2, 2'h0, 2'h1, 4'h6);
        run(5'h12, 3'h4, 2'h0, 2'h2, 4'h6);
        run(5'h13, 3'h3, 2'h0, 2'h3, 4'h6);
        run(5'h14, 3'h0, 2'h0, 2'h2, 4'h6);
        run(5'h15, 3'h0, 2'h0, 2'h1, 4'h8);
        run(5'h16, 3'h0, 2'h0, 2'h1, 4'h8);
        // Pointer moves: both pointers, all four modes
        for (int i = 0; i < 8; i++) begin
            run(5'(8'h18 + i), 3'h0, 2'h3, 2'h1, 4'h8);
            check("ptr sel", dec_ptr_sel, i / 4);
            check("ptr mode", dec_ptr_mode, i % 4);
        end
        run(5'h1C, 3'h4, 2'h3, 2'h2, 4'h8);
        conclude();
    end
endmodule
